// >>> hw/rcb_pkg.sv
// Constants, types and BCD helpers for the battery-backed calendar clock
package rcb_pkg;
  // Synchronised pin positions
  localparam int PIN_N     = 8;
  localparam int PIN_XTAL  = 0;
  localparam int PIN_OSC   = 1;
  localparam int PIN_LPRC  = 2;
  localparam int PIN_FEXT  = 3;
  localparam int PIN_REF   = 4;
  localparam int PIN_TAMP0 = 5;
  localparam int PIN_TS    = 7;
  // Sizes
  localparam int BKP_N   = 5;
  localparam int BKP_W   = 32;
  localparam int SHIFT_W = 15;
  localparam int WUT_W   = 17;
  localparam int CAL_W   = 20;
  // Fast external clock divided by 32: terminal count
  localparam logic [4:0] FEXT_LAST = 5'h1F;
  // Pulses inserted per calibration window when adding
  localparam logic [9:0] CAL_ADD = 10'h200;
  // Reference edges per second, minus one
  localparam logic [5:0] REF50_LAST = 6'h31;
  localparam logic [5:0] REF60_LAST = 6'h3B;
  // BCD limits and reset values
  localparam logic [7:0] BCD_ZERO  = 8'h00;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] SEC_LAST  = 8'h59;
  localparam logic [7:0] H24_LAST  = 8'h23;
  localparam logic [7:0] H12_TOP   = 8'h12;
  localparam logic [7:0] H12_FLIP  = 8'h11;
  localparam logic [7:0] MON_LAST  = 8'h12;
  localparam logic [7:0] MON_FEB   = 8'h02;
  localparam logic [7:0] DAYS_28   = 8'h28;
  localparam logic [7:0] DAYS_29   = 8'h29;
  localparam logic [7:0] DAYS_30   = 8'h30;
  localparam logic [7:0] DAYS_31   = 8'h31;
  localparam logic [2:0] WDAY_ONE  = 3'h1;
  localparam logic [2:0] WDAY_LAST = 3'h7;
  // Clock source selection
  typedef enum logic [1:0] {
    CS_XTAL = 2'b00, CS_OSC = 2'b01, CS_LPRC = 2'b10, CS_FEXT = 2'b11
  } rcb_clksel_t;
  // Next BCD value, no wrap
  function automatic logic [7:0] rcb_bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction
  // Leap year from a two-digit BCD year
  function automatic logic rcb_leap(input logic [7:0] y);
    return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction
  // Last date of a month, BCD
  function automatic logic [7:0] rcb_dim(input logic [7:0] m, input logic [7:0] y);
    if (m == MON_FEB) return rcb_leap(y) ? DAYS_29 : DAYS_28;
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) return DAYS_30;
    return DAYS_31;
  endfunction
endpackage

// >>> hw/rcb_clock.sv
// Calendar clock with backup store, alarms, wakeup timer, tamper and timestamp
`timescale 1ns/1ps
module rcb_clock
  import rcb_pkg::*;
#(
  parameter int APRE_W = 7,
  parameter int SPRE_W = 15
) (
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  input  wire logic              i_xtal_pin,
  input  wire logic              i_osc_pin,
  input  wire logic              i_lprc_pin,
  input  wire logic              i_fext_pin,
  input  wire logic              i_ref_pin,
  input  wire logic [1:0]        i_tamp_pin,
  input  wire logic              i_ts_pin,
  input  wire logic [1:0]        i_clk_sel,
  input  wire logic [APRE_W-1:0] i_apre_div,
  input  wire logic [SPRE_W-1:0] i_spre_div,
  input  wire logic [8:0]        i_cal_minus,
  input  wire logic              i_cal_plus,
  input  wire logic              i_shift_go,
  input  wire logic              i_shift_add1s,
  input  wire logic [SHIFT_W-1:0] i_shift_subfs,
  input  wire logic              i_ref_en,
  input  wire logic              i_ref_50,
  input  wire logic              i_init,
  input  wire logic              i_fmt12,
  input  wire logic [7:0]        i_set_sec,
  input  wire logic [7:0]        i_set_min,
  input  wire logic [7:0]        i_set_hour,
  input  wire logic              i_set_pm,
  input  wire logic [2:0]        i_set_wday,
  input  wire logic [7:0]        i_set_date,
  input  wire logic [7:0]        i_set_mon,
  input  wire logic [7:0]        i_set_year,
  input  wire logic [1:0]        i_alm_en,
  input  wire logic [1:0][3:0]   i_alm_mask,
  input  wire logic [1:0][7:0]   i_alm_sec,
  input  wire logic [1:0][7:0]   i_alm_min,
  input  wire logic [1:0][7:0]   i_alm_hour,
  input  wire logic [1:0][7:0]   i_alm_date,
  input  wire logic [1:0]        i_alm_clr,
  input  wire logic              i_wut_en,
  input  wire logic              i_wut_fast,
  input  wire logic [WUT_W-1:0]  i_wut_reload,
  input  wire logic              i_wut_clr,
  input  wire logic [1:0]        i_tamp_en,
  input  wire logic [1:0]        i_tamp_filt,
  input  wire logic              i_tamp_ts,
  input  wire logic [1:0]        i_tamp_clr,
  input  wire logic              i_ts_en,
  input  wire logic              i_ts_clr,
  input  wire logic              i_bkp_we,
  input  wire logic [2:0]        i_bkp_idx,
  input  wire logic [BKP_W-1:0]  i_bkp_wdata,
  input  wire logic [2:0]        i_bkp_ridx,
  output logic [BKP_W-1:0]       o_bkp_rdata,
  output logic [SPRE_W-1:0]      o_subsec,
  output logic [7:0]             o_sec,
  output logic [7:0]             o_min,
  output logic [7:0]             o_hour,
  output logic                   o_pm,
  output logic [2:0]             o_wday,
  output logic [7:0]             o_date,
  output logic [7:0]             o_mon,
  output logic [7:0]             o_year,
  output logic                   o_shift_busy,
  output logic [1:0]             o_alm_flag,
  output logic                   o_wut_flag,
  output logic [1:0]             o_tamp_flag,
  output logic                   o_ts_flag,
  output logic                   o_ts_ovf,
  output logic [31:0]            o_ts_time,
  output logic                   o_wakeup
);
  // Refuse prescaler widths the chain cannot serve
  if (APRE_W < 1 || APRE_W > 16 || SPRE_W < 1 || SPRE_W > 16) begin : g_chk
    $error("rcb_clock: prescaler width out of range");
  end

  // Pin synchronisers and qualified levels
  logic [PIN_N-1:0] s1_q, s2_q, s3_q, stab_q;
  logic [PIN_N-1:0] pins_w, stab_d, rise_w;
  assign pins_w = {i_ts_pin, i_tamp_pin, i_ref_pin, i_fext_pin,
                   i_lprc_pin, i_osc_pin, i_xtal_pin};
  // A level changes once the second and third stages agree
  assign stab_d = (s2_q & s3_q) | (stab_q & (s2_q | s3_q));
  assign rise_w = stab_d & ~stab_q;
  // Three-stage capture of all pins
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      stab_q <= '0;
    end else begin
      s1_q   <= pins_w;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= stab_d;
    end
  end

  // Source selection; fast external clock is divided by 32
  logic [4:0] fdiv_q;
  logic       fext_tick, raw_tick;
  assign fext_tick = rise_w[PIN_FEXT] && fdiv_q == FEXT_LAST;
  assign raw_tick  = (i_clk_sel == CS_FEXT) ? fext_tick : rise_w[i_clk_sel];

  // Calibration window: mask pulses, optionally insert 512
  logic [CAL_W-1:0] cal_cnt_q;
  logic [9:0]       ins_q;
  logic             cal_mask, ins_fire, cal_tick;
  assign cal_mask = raw_tick && cal_cnt_q < {11'h000, i_cal_minus};
  assign ins_fire = !raw_tick && ins_q != 10'h000;
  assign cal_tick = (raw_tick && !cal_mask) || ins_fire;

  // Prescalers, shift and reference
  logic [APRE_W-1:0]  apre_q;
  logic [SPRE_W-1:0]  spre_q;
  logic [SHIFT_W-1:0] shf_q;
  logic [5:0]         ref_q;
  logic               ck_apre, pre_sec, ref_sec, add1s, sec_tick, tick_q;
  assign ck_apre  = cal_tick && apre_q == '0;
  assign pre_sec  = ck_apre && shf_q == '0 && spre_q == '0;
  assign ref_sec  = rise_w[PIN_REF] && ref_q == (i_ref_50 ? REF50_LAST : REF60_LAST);
  assign add1s    = i_shift_go && i_shift_add1s && shf_q == '0;
  assign sec_tick = !i_init && ((i_ref_en ? ref_sec : pre_sec) || add1s);

  // Clock chain registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      fdiv_q    <= '0;
      cal_cnt_q <= '0;
      ins_q     <= '0;
      apre_q    <= '0;
      spre_q    <= '0;
      shf_q     <= '0;
      ref_q     <= '0;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= sec_tick;
      // Divide-by-32 counter
      if (rise_w[PIN_FEXT]) begin
        fdiv_q <= fdiv_q + 5'h01;
      end
      // Window of 2^20 source pulses
      if (raw_tick) begin
        cal_cnt_q <= cal_cnt_q + 1'b1;
      end
      // Load insert budget at window start, spend it on idle cycles
      if (raw_tick && cal_cnt_q == '0 && i_cal_plus) begin
        ins_q <= CAL_ADD;
      end else if (ins_fire) begin
        ins_q <= ins_q - 10'h001;
      end
      // Shift delays the chain by swallowing prescaled pulses
      if (i_shift_go && shf_q == '0) begin
        shf_q <= i_shift_subfs;
      end else if (ck_apre && shf_q != '0) begin
        shf_q <= shf_q - 1'b1;
      end
      // Prescalers reload from software values
      if (i_init) begin
        apre_q <= i_apre_div;
        spre_q <= i_spre_div;
      end else begin
        if (cal_tick) begin
          apre_q <= (apre_q == '0) ? i_apre_div : apre_q - 1'b1;
        end
        if (ck_apre && shf_q == '0) begin
          spre_q <= (spre_q == '0) ? i_spre_div : spre_q - 1'b1;
        end
      end
      // Reference edge counter
      if (!i_ref_en || i_init) begin
        ref_q <= '0;
      end else if (rise_w[PIN_REF]) begin
        ref_q <= ref_sec ? 6'h00 : ref_q + 6'h01;
      end
    end
  end

  // Calendar state
  logic [7:0] sec_q, min_q, hour_q, date_q, mon_q, year_q;
  logic [2:0] wday_q;
  logic       pm_q;
  logic       sec_wrap, min_wrap, hour_top, day_roll, date_wrap, mon_wrap;
  assign sec_wrap  = sec_q == SEC_LAST;
  assign min_wrap  = min_q == SEC_LAST;
  assign hour_top  = i_fmt12 ? (hour_q == H12_FLIP && pm_q) : hour_q == H24_LAST;
  assign day_roll  = sec_wrap && min_wrap && hour_top;
  assign date_wrap = date_q == rcb_dim(mon_q, year_q);
  assign mon_wrap  = mon_q == MON_LAST;

  // BCD calendar advance on each second
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sec_q  <= BCD_ZERO;
      min_q  <= BCD_ZERO;
      hour_q <= BCD_ZERO;
      pm_q   <= 1'b0;
      wday_q <= WDAY_ONE;
      date_q <= BCD_ONE;
      mon_q  <= BCD_ONE;
      year_q <= BCD_ZERO;
    end else if (i_init) begin
      sec_q  <= i_set_sec;
      min_q  <= i_set_min;
      hour_q <= i_set_hour;
      pm_q   <= i_set_pm;
      wday_q <= i_set_wday;
      date_q <= i_set_date;
      mon_q  <= i_set_mon;
      year_q <= i_set_year;
    end else if (sec_tick) begin
      sec_q <= sec_wrap ? BCD_ZERO : rcb_bcd_inc(sec_q);
      if (sec_wrap) begin
        min_q <= min_wrap ? BCD_ZERO : rcb_bcd_inc(min_q);
      end
      if (sec_wrap && min_wrap) begin
        if (i_fmt12) begin
          hour_q <= (hour_q == H12_TOP) ? BCD_ONE : rcb_bcd_inc(hour_q);
          pm_q   <= pm_q ^ (hour_q == H12_FLIP);
        end else begin
          hour_q <= hour_top ? BCD_ZERO : rcb_bcd_inc(hour_q);
        end
      end
      if (day_roll) begin
        wday_q <= (wday_q == WDAY_LAST) ? WDAY_ONE : wday_q + 3'h1;
        date_q <= date_wrap ? BCD_ONE : rcb_bcd_inc(date_q);
        if (date_wrap) begin
          mon_q <= mon_wrap ? BCD_ONE : rcb_bcd_inc(mon_q);
        end
        if (date_wrap && mon_wrap) begin
          year_q <= rcb_bcd_inc(year_q) == 8'hA0 ? BCD_ZERO : rcb_bcd_inc(year_q);
        end
      end
    end
  end

  // Alarms and tamper channels
  logic [1:0] alm_q, alm_hit, tamp_q, tev_w;
  logic [1:0][3:0] tcnt_q;
  for (genvar g = 0; g < 2; g++) begin : g_ch
    // Fields compared after each calendar update, masked fields always match
    assign alm_hit[g] = i_alm_en[g] && tick_q
                        && (i_alm_mask[g][0] || sec_q == i_alm_sec[g])
                        && (i_alm_mask[g][1] || min_q == i_alm_min[g])
                        && (i_alm_mask[g][2] || hour_q == i_alm_hour[g])
                        && (i_alm_mask[g][3] || date_q == i_alm_date[g]);
    logic       lvl;
    logic [3:0] lim;
    assign lvl = stab_q[PIN_TAMP0+g];
    assign lim = 4'h1 << i_tamp_filt;
    // Filter off: edge; on: level held for 2, 4 or 8 prescaled samples
    assign tev_w[g] = i_tamp_en[g] && ((i_tamp_filt == 2'b00) ? rise_w[PIN_TAMP0+g]
                      : (ck_apre && lvl && tcnt_q[g] == lim - 4'h1));
    // Flags: a new event wins over a clear
    always_ff @(posedge i_clock) begin
      if (i_reset) begin
        alm_q[g]  <= 1'b0;
        tamp_q[g] <= 1'b0;
        tcnt_q[g] <= '0;
      end else begin
        alm_q[g]  <= alm_hit[g] || (alm_q[g] && !i_alm_clr[g]);
        tamp_q[g] <= tev_w[g] || (tamp_q[g] && !i_tamp_clr[g]);
        if (!lvl) begin
          tcnt_q[g] <= '0;
        end else if (ck_apre && tcnt_q[g] != lim) begin
          tcnt_q[g] <= tcnt_q[g] + 4'h1;
        end
      end
    end
  end

  // Timestamp, wakeup counter and wake line
  logic             ts_ev, wut_tick, wut_hit, ts_q, ovf_q, wut_q, wake_q;
  logic [WUT_W-1:0] wut_cnt_q;
  logic [31:0]      ts_time_q;
  assign ts_ev    = (i_ts_en && rise_w[PIN_TS]) || (i_tamp_ts && tev_w != 2'b00);
  assign wut_tick = i_wut_en && (i_wut_fast ? ck_apre : sec_tick);
  assign wut_hit  = wut_tick && wut_cnt_q == '0;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ts_q      <= 1'b0;
      ovf_q     <= 1'b0;
      ts_time_q <= '0;
      wut_q     <= 1'b0;
      wut_cnt_q <= '0;
      wake_q    <= 1'b0;
    end else begin
      ts_q  <= ts_ev || (ts_q && !i_ts_clr);
      ovf_q <= (ts_ev && ts_q && !i_ts_clr) || (ovf_q && !i_ts_clr);
      if (ts_ev && !(ts_q && !i_ts_clr)) begin
        ts_time_q <= {hour_q, min_q, sec_q, date_q};
      end
      if (!i_wut_en) begin
        wut_cnt_q <= i_wut_reload;
      end else if (wut_tick) begin
        wut_cnt_q <= wut_hit ? i_wut_reload : wut_cnt_q - 1'b1;
      end
      wut_q  <= wut_hit || (wut_q && !i_wut_clr);
      wake_q <= alm_q != 2'b00 || tamp_q != 2'b00 || ts_q || wut_q;
    end
  end

  // Backup store: deliberately outside every reset
  logic [BKP_N-1:0][BKP_W-1:0] bkp_q;
  logic [BKP_W-1:0]            bkp_rd_q;
  always_ff @(posedge i_clock) begin
    if (i_bkp_we && i_bkp_idx < 3'(BKP_N)) begin
      bkp_q[i_bkp_idx] <= i_bkp_wdata;
    end
    bkp_rd_q <= (i_bkp_ridx < 3'(BKP_N)) ? bkp_q[i_bkp_ridx] : '0;
  end

  assign o_bkp_rdata  = bkp_rd_q;
  assign o_subsec     = spre_q;
  assign o_sec        = sec_q;
  assign o_min        = min_q;
  assign o_hour       = hour_q;
  assign o_pm         = pm_q;
  assign o_wday       = wday_q;
  assign o_date       = date_q;
  assign o_mon        = mon_q;
  assign o_year       = year_q;
  assign o_shift_busy = shf_q != '0;
  assign o_alm_flag   = alm_q;
  assign o_wut_flag   = wut_q;
  assign o_tamp_flag  = tamp_q;
  assign o_ts_flag    = ts_q;
  assign o_ts_ovf     = ovf_q;
  assign o_ts_time    = ts_time_q;
  assign o_wakeup     = wake_q;

  // Checks
  AST_BKP_WRITE: assert property (@(posedge i_clock) i_bkp_we && i_bkp_idx == 3'h0
    |=> bkp_q[0] == $past(i_bkp_wdata)) else $error("backup write lost");
  // Case equality: words never written hold no defined value yet must not move
  AST_BKP_KEEP: assert property (@(posedge i_clock) i_reset && !i_bkp_we
    |=> bkp_q === $past(bkp_q)) else $error("backup changed by reset");
  AST_SEC_WRAP: assert property (@(posedge i_clock) disable iff (i_reset)
    sec_tick && sec_wrap && !min_wrap |=> sec_q == BCD_ZERO && min_q == rcb_bcd_inc($past(min_q)))
    else $error("second rollover wrong");
  AST_MONTH_END: assert property (@(posedge i_clock) disable iff (i_reset)
    sec_tick && day_roll && date_wrap |=> date_q == BCD_ONE && mon_q != $past(mon_q))
    else $error("month end wrong");
  AST_REF_SEC: assert property (@(posedge i_clock) disable iff (i_reset)
    sec_tick && i_ref_en && !add1s |-> rise_w[PIN_REF]) else $error("reference second");
  AST_ALM_WAKE: assert property (@(posedge i_clock) disable iff (i_reset)
    alm_hit[0] |=> alm_q[0] ##1 o_wakeup) else $error("alarm did not wake");
  AST_SHIFT: assert property (@(posedge i_clock) disable iff (i_reset)
    i_shift_go && !o_shift_busy && i_shift_subfs != '0 |=> o_shift_busy)
    else $error("shift not taken");
  AST_CAL_MASK: assert property (@(posedge i_clock) disable iff (i_reset)
    cal_mask && !i_init |=> spre_q == $past(spre_q) && apre_q == $past(apre_q))
    else $error("masked pulse passed");
  AST_TAMP_TS: assert property (@(posedge i_clock) disable iff (i_reset)
    tev_w[0] && i_tamp_ts |=> tamp_q[0] && ts_q) else $error("tamper timestamp");
  AST_WUT: assert property (@(posedge i_clock) disable iff (i_reset)
    wut_hit |=> wut_q && wut_cnt_q == $past(i_wut_reload) ##1 o_wakeup)
    else $error("wakeup counter");
  AST_PRE_SEC: assert property (@(posedge i_clock) disable iff (i_reset)
    pre_sec && !i_ref_en && !i_init |=> sec_q != $past(sec_q))
    else $error("prescaler second lost");
  COV_ALARM: cover property (@(posedge i_clock) disable iff (i_reset) alm_hit[1]);
  COV_LEAP: cover property (@(posedge i_clock) disable iff (i_reset)
    sec_tick && day_roll && date_wrap && date_q == DAYS_29);
  COV_TS: cover property (@(posedge i_clock) disable iff (i_reset) ts_ev && ts_q);
endmodule

// >>> bench/rcb_clock_tb_top.sv
// Self-checking bench for the battery-backed calendar clock
`timescale 1ns/1ps
module rcb_clock_tb_top;
  import rcb_pkg::*;
  // Clock, reset and source pins, pins paced by the wave process
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_xtal_pin = 1'b0, i_osc_pin = 1'b0, i_lprc_pin = 1'b0;
  logic        i_fext_pin = 1'b0, i_ref_pin = 1'b0;
  // Control inputs
  logic        i_ts_pin, i_cal_plus, i_shift_go, i_shift_add1s, i_ref_en, i_ref_50, i_init;
  logic        i_fmt12, i_set_pm, i_wut_en, i_wut_fast, i_wut_clr, i_tamp_ts, i_ts_en;
  logic        i_ts_clr, i_bkp_we;
  logic [1:0]  i_tamp_pin, i_clk_sel, i_alm_en, i_alm_clr, i_tamp_en, i_tamp_filt, i_tamp_clr;
  logic [2:0]  i_set_wday, i_bkp_idx, i_bkp_ridx;
  logic [7:0]  i_set_sec, i_set_min, i_set_hour, i_set_date, i_set_mon, i_set_year;
  logic [1:0][3:0] i_alm_mask;
  logic [1:0][7:0] i_alm_sec, i_alm_min, i_alm_hour, i_alm_date;
  logic [8:0]  i_cal_minus;
  logic [6:0]  i_apre_div;
  logic [14:0] i_spre_div;
  logic [SHIFT_W-1:0] i_shift_subfs;
  logic [WUT_W-1:0]   i_wut_reload;
  logic [BKP_W-1:0]   i_bkp_wdata, o_bkp_rdata;
  // Observed outputs
  logic [14:0] o_subsec;
  logic [7:0]  o_sec, o_min, o_hour, o_date, o_mon, o_year;
  logic        o_pm, o_shift_busy, o_wut_flag, o_ts_flag, o_ts_ovf, o_wakeup;
  logic [2:0]  o_wday;
  logic [1:0]  o_alm_flag, o_tamp_flag;
  logic [31:0] o_ts_time;
  // Bench bookkeeping
  int          errors = 0;
  int          tests_run = 0;
  logic [4:0]  pin_on = 5'h00;
  logic [2:0]  wave_cnt = 3'h0;
  // Month-end cases: date, month, year before; date, month, year after
  localparam logic [47:0] MEND [6] = '{48'h2802_2429_0224, 48'h2902_2401_0324,
    48'h2802_2301_0323, 48'h3004_2301_0523, 48'h3005_2331_0523, 48'h3112_9901_0100};

  rcb_clock #(.APRE_W(7), .SPRE_W(15)) dut (.i_clock, .i_reset, .i_xtal_pin, .i_osc_pin,
    .i_lprc_pin, .i_fext_pin, .i_ref_pin, .i_tamp_pin, .i_ts_pin, .i_clk_sel, .i_apre_div,
    .i_spre_div, .i_cal_minus, .i_cal_plus, .i_shift_go, .i_shift_add1s, .i_shift_subfs,
    .i_ref_en, .i_ref_50, .i_init, .i_fmt12, .i_set_sec, .i_set_min, .i_set_hour, .i_set_pm,
    .i_set_wday, .i_set_date, .i_set_mon, .i_set_year, .i_alm_en, .i_alm_mask, .i_alm_sec,
    .i_alm_min, .i_alm_hour, .i_alm_date, .i_alm_clr, .i_wut_en, .i_wut_fast, .i_wut_reload,
    .i_wut_clr, .i_tamp_en, .i_tamp_filt, .i_tamp_ts, .i_tamp_clr, .i_ts_en, .i_ts_clr,
    .i_bkp_we, .i_bkp_idx, .i_bkp_wdata, .i_bkp_ridx, .o_bkp_rdata, .o_subsec, .o_sec,
    .o_min, .o_hour, .o_pm, .o_wday, .o_date, .o_mon, .o_year, .o_shift_busy, .o_alm_flag,
    .o_wut_flag, .o_tamp_flag, .o_ts_flag, .o_ts_ovf, .o_ts_time, .o_wakeup);

  // 20 MHz clock
  always #25 i_clock = ~i_clock;

  // Enabled source pins toggle with an 8-cycle period
  always @(negedge i_clock) begin
    wave_cnt <= wave_cnt + 3'h1;
    {i_ref_pin, i_fext_pin, i_lprc_pin, i_osc_pin, i_xtal_pin} <= pin_on & {5{wave_cnt[2]}};
  end

  // Compare one value, count and report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts, verdict and stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // Wait for the seconds field to move; n is the cycles waited
  task automatic tick(output int n);
    logic [7:0] old;
    old = o_sec;
    n = 0;
    while (o_sec === old) begin
      @(negedge i_clock);
      n++;
      if (n > 1200) begin
        errors++;
        $display("[ERR] seconds never advanced");
        end_of_test();
      end
    end
  endtask

  // Load the calendar through the init level
  task automatic set_time(input logic [7:0] h, mi, s, d, mo, y);
    @(negedge i_clock);
    {i_set_hour, i_set_min, i_set_sec, i_set_date, i_set_mon, i_set_year} = {h, mi, s, d, mo, y};
    i_init = 1'b1;
    cyc(2);
    i_init = 1'b0;
  endtask

  // Backup word access, read data one cycle after the index
  task automatic bkp_wr(input logic [2:0] idx, input logic [31:0] d);
    @(negedge i_clock);
    {i_bkp_idx, i_bkp_wdata, i_bkp_we} = {idx, d, 1'b1};
    @(negedge i_clock);
    i_bkp_we = 1'b0;
  endtask
  task automatic bkp_rd(input logic [2:0] idx, output logic [31:0] d);
    @(negedge i_clock);
    i_bkp_ridx = idx;
    @(negedge i_clock);
    d = o_bkp_rdata;
  endtask

  // Calendar and flags right after a reset
  task automatic chk_reset();
    check("time", {o_hour, o_min, o_sec, o_date}, 32'h0000_0001);
    check("mon_year_wday", {o_mon, o_year, 5'h00, o_wday, 8'h00}, 32'h0100_0100);
    check("flags", {o_alm_flag, o_wut_flag, o_tamp_flag, o_ts_flag, o_wakeup}, 32'h0);
  endtask

  // Main sequence
  initial begin
    int n;
    logic [31:0] rd;
    {i_tamp_pin, i_ts_pin, i_clk_sel, i_apre_div, i_cal_minus, i_cal_plus, i_shift_go,
     i_shift_add1s, i_shift_subfs, i_ref_en, i_ref_50, i_init, i_fmt12, i_set_sec, i_set_min,
     i_set_hour, i_set_pm, i_set_date, i_set_mon, i_set_year, i_alm_en, i_alm_mask, i_alm_sec,
     i_alm_min, i_alm_hour, i_alm_date, i_alm_clr, i_wut_en, i_wut_fast, i_wut_reload,
     i_wut_clr, i_tamp_en, i_tamp_filt, i_tamp_ts, i_tamp_clr, i_ts_en, i_ts_clr, i_bkp_we,
     i_bkp_idx, i_bkp_wdata, i_bkp_ridx} = '0;
    i_spre_div = 15'h0001;
    i_set_wday = 3'h7;
    cyc(10);
    i_reset = 1'b0;
    chk_reset();
    // Backup words, then a reset in mid-run must leave them intact
    for (int i = 0; i < 6; i++) bkp_wr(i[2:0], 32'hC0DE_0000 | i);
    i_reset = 1'b1;
    cyc(2);
    i_reset = 1'b0;
    chk_reset();
    for (int i = 0; i < 6; i++) begin
      bkp_rd(i[2:0], rd);
      check("backup", rd, (i < 5) ? (32'hC0DE_0000 | i) : 32'h0);
    end
    // Each source alone drives the prescaler chain; the others are ignored
    for (int s = 0; s < 4; s++) begin
      i_clk_sel = s[1:0];
      i_spre_div = (s == 1) ? 15'h0003 : 15'h0001;
      pin_on = 5'h0F ^ (5'h01 << s);
      set_time(8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00);
      cyc(100);
      check("idle_src", o_sec, 8'h00);
      check("subsec_hold", o_subsec, (s == 1) ? 32'h3 : 32'h1);
      pin_on = 5'h01 << s;
      tick(n);
      tick(n);
      check("tick_period", n, (s == 3) ? 512 : ((s == 1) ? 32 : 16));
    end
    i_clk_sel = 2'h0;
    i_spre_div = 15'h0001;
    // Reference alone paces seconds: 50 or 60 edges of 8 cycles
    for (int r = 0; r < 2; r++) begin
      {pin_on, i_ref_en, i_ref_50} = {5'h10, 1'b1, r[0]};
      tick(n);
      tick(n);
      check("ref_period", n, r ? 400 : 480);
    end
    {pin_on, i_ref_en} = {5'h01, 1'b0};
    // Month ends, year wrap and weekday wrap from 23:59:59
    for (int i = 0; i < 6; i++) begin
      set_time(8'h23, 8'h59, 8'h59, MEND[i][47:40], MEND[i][39:32], MEND[i][31:24]);
      tick(n);
      check("date_mon_year", {o_date, o_mon, o_year}, MEND[i][23:0]);
      check("hms_wday", {o_hour, o_min, o_sec, 5'h00, o_wday}, 32'h0000_0001);
    end
    // 12-hour format crossings
    i_fmt12 = 1'b1;
    set_time(8'h11, 8'h59, 8'h59, 8'h01, 8'h01, 8'h00);
    tick(n);
    check("h12_noon", {o_hour, 7'h00, o_pm}, 16'h1201);
    set_time(8'h12, 8'h59, 8'h59, 8'h01, 8'h01, 8'h00);
    tick(n);
    check("h12_one", {o_hour, 7'h00, o_pm}, 16'h0100);
    i_fmt12 = 1'b0;
    // Two alarms on seconds only, each with its own match
    {i_alm_mask, i_alm_sec, i_alm_en} = {8'hEE, 8'h05, 8'h04, 2'h3};
    set_time(8'h00, 8'h00, 8'h03, 8'h01, 8'h01, 8'h00);
    tick(n);
    cyc(4);
    check("alarm_first", {o_alm_flag, o_wakeup}, 3'h3);
    tick(n);
    cyc(4);
    check("alarm_both", o_alm_flag, 2'h3);
    i_alm_clr = 2'h3;
    cyc(1);
    {i_alm_clr, i_alm_en} = 4'h0;
    cyc(3);
    check("alarm_clear", {o_alm_flag, o_wakeup}, 3'h0);
    // Wakeup counter: reload 2 gives a period of three seconds
    // Reload is taken while disabled, so it must stand a cycle before enabling
    i_wut_reload = 17'h0_0002;
    cyc(1);
    i_wut_en = 1'b1;
    tick(n);
    tick(n);
    cyc(4);
    check("wut_early", o_wut_flag, 1'b0);
    tick(n);
    cyc(4);
    check("wut_expire", {o_wut_flag, o_wakeup}, 2'h3);
    {i_wut_clr, i_wut_en} = 2'h2;
    cyc(1);
    i_wut_clr = 1'b0;
    // Timestamp on the pin with the calendar frozen, then overflow
    pin_on = 5'h00;
    i_ts_en = 1'b1;
    set_time(8'h13, 8'h45, 8'h27, 8'h19, 8'h07, 8'h21);
    for (int k = 0; k < 2; k++) begin
      i_ts_pin = 1'b1;
      cyc(8);
      i_ts_pin = 1'b0;
      cyc(8);
      check("ts_time", o_ts_time, 32'h1345_2719);
      check("ts_flags", {o_ts_flag, o_ts_ovf, o_wakeup}, k ? 3'h7 : 3'h5);
    end
    i_ts_clr = 1'b1;
    cyc(1);
    i_ts_clr = 1'b0;
    // Tamper on pin 0, edge mode, also timestamps
    {pin_on, i_tamp_en, i_tamp_ts} = {5'h01, 2'h1, 1'b1};
    i_tamp_pin = 2'h1;
    cyc(40);
    check("tamp0", {o_tamp_flag, o_ts_flag, o_wakeup}, 4'h7);
    // Eight-sample filter rejects a short pulse on pin 1 and takes a long one
    {i_tamp_en, i_tamp_filt, i_tamp_pin} = {2'h3, 2'h3, 2'h2};
    cyc(20);
    i_tamp_pin = 2'h0;
    cyc(20);
    check("tamp1_short", o_tamp_flag, 2'h1);
    i_tamp_pin = 2'h2;
    cyc(120);
    check("tamp1_long", o_tamp_flag, 2'h3);
    // Shift: add one second, then a refused request while busy
    pin_on = 5'h00;
    set_time(8'h00, 8'h00, 8'h10, 8'h01, 8'h01, 8'h00);
    for (int k = 0; k < 2; k++) begin
      {i_shift_subfs, i_shift_add1s, i_shift_go} = {15'h0003, 2'h3};
      cyc(1);
      i_shift_go = 1'b0;
      cyc(1);
      check("shift_busy_sec", {o_shift_busy, o_sec}, 9'h111);
    end
    pin_on = 5'h01;
    cyc(60);
    check("shift_done", o_shift_busy, 1'b0);
    // Calibration: reset one source period after a tick keeps the pin phase known
    tick(n);
    {i_reset, i_cal_minus} = {1'b1, 9'h004};
    cyc(8);
    i_reset = 1'b0;
    chk_reset();
    tick(n);
    check("cal_minus", n, 40);
    // 512 inserted pulses plus 74 source pulses give 293 seconds
    {i_reset, i_cal_minus, i_cal_plus} = {1'b1, 9'h000, 1'b1};
    cyc(8);
    i_reset = 1'b0;
    cyc(598);
    check("cal_plus", {o_min, o_sec}, 16'h0453);
    end_of_test();
  end
endmodule
